// file: byte_timer_cfg.svh
/*
 * Constants of the dual 8-bit timer block: register indices, field
 * codes, reset values and divider limits.
 * Assumes it is included by bare name after the type package is compiled.
 */
`ifndef BYTE_TIMER_CFG_SVH
`define BYTE_TIMER_CFG_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------
`define IDX_BOUND_A 8'h09
`define IDX_DIV_A 8'h17
`define IDX_CTRL_A 8'h1C
`define IDX_COUNT_A 8'h1D
`define IDX_CTRL_B 8'h32
`define IDX_COUNT_B 8'h33
`define IDX_DIV_B 8'h34
`define IDX_BOUND_B 8'h35

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CTRL 8'h00
`define RST_DIV 8'h00
`define RST_BOUND 8'h00
`define RST_COUNT 8'h00

// ----------------------------------------------------------------------
// Field limits and bus answers
// ----------------------------------------------------------------------
`define PRE_LIM_1 6'h00
`define PRE_LIM_4 6'h03
`define PRE_LIM_16 6'h0F
`define PRE_LIM_64 6'h3F
`define PWM_MAX_8 8'hFF
`define PWM_MAX_7 8'h7F
`define PWM_MAX_6 8'h3F
`define OUT_NONE 2'h0
`define OUT_PIN1 2'h1
`define OUT_PIN2 2'h2
`define OUT_PIN3 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: byte_timer_pkg.sv
/*
 * Types of the dual 8-bit timer block.
 * Assumes the constants header is included where numbers are needed.
 */
`default_nettype none
package byte_timer_pkg;

    typedef enum logic [3:0] {
        CS_OFF = 4'b0000,
        CS_SYS = 4'b0001,
        CS_FAST = 4'b0010,
        CS_EXT = 4'b0011,
        CS_SLOW = 4'b0100,
        CS_CMP = 4'b0101,
        CS_PA0_RISE = 4'b1000,
        CS_PA0_FALL = 4'b1001,
        CS_PB0_RISE = 4'b1010,
        CS_PB0_FALL = 4'b1011,
        CS_PA4_RISE = 4'b1100,
        CS_PA4_FALL = 4'b1101
    } clk_src_type;

    typedef struct packed {
        logic [3:0] clk_sel;
        logic [1:0] out_sel;
        logic pwm_mode;
        logic invert;
    } ctrl_type;

    typedef struct packed {
        logic narrow;
        logic [1:0] prescale;
        logic [4:0] scale;
    } div_type;

    typedef struct packed {
        logic fast_osc;
        logic ext_osc;
        logic slow_osc;
        logic cmp_out;
        logic port_a_bit0;
        logic port_b_bit0;
        logic port_a_bit4;
    } src_type;

    typedef struct packed {
        logic port_b_bit2;
        logic port_a_bit3;
        logic port_b_bit4;
        logic port_b_bit5;
        logic port_b_bit6;
        logic port_b_bit7;
    } pin_type;

    typedef enum logic [3:0] {
        SEL_NONE = 4'b0000,
        SEL_BOUND_A = 4'b0001,
        SEL_DIV_A = 4'b0010,
        SEL_CTRL_A = 4'b0011,
        SEL_COUNT_A = 4'b0100,
        SEL_CTRL_B = 4'b0101,
        SEL_COUNT_B = 4'b0110,
        SEL_DIV_B = 4'b0111,
        SEL_BOUND_B = 4'b1000
    } reg_sel_type;

endpackage : byte_timer_pkg
`default_nettype wire

// file: tick_select.sv
/*
 * Picks the counting event of one timer from its clock-select code.
 * Assumes all source levels are synchronous to aclk.
 */
`default_nettype none
module tick_select
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] clk_sel,
    input wire byte_timer_pkg::src_type src,
    input wire logic fast_osc_doubling_option,
    input wire logic ice_halt,
    output logic tick
);
    import byte_timer_pkg::*;

    src_type prev_r;
    src_type prev_nxt;
    src_type rise;
    src_type fall;
    logic raw;

    always_comb
    begin
        prev_nxt = src;
        rise = src & ~prev_r;
        fall = ~src & prev_r;
        case (clk_sel)
            CS_OFF: raw = 1'b0;
            CS_SYS: raw = 1'b1;
            CS_FAST: raw = fast_osc_doubling_option ?
                (rise.fast_osc | fall.fast_osc) : rise.fast_osc;
            CS_EXT: raw = rise.ext_osc;
            CS_SLOW: raw = rise.slow_osc;
            CS_CMP: raw = rise.cmp_out | fall.cmp_out;
            CS_PA0_RISE: raw = rise.port_a_bit0;
            CS_PA0_FALL: raw = fall.port_a_bit0;
            CS_PB0_RISE: raw = rise.port_b_bit0;
            CS_PB0_FALL: raw = fall.port_b_bit0;
            CS_PA4_RISE: raw = rise.port_a_bit4;
            CS_PA4_FALL: raw = fall.port_a_bit4;
            default: raw = 1'b0;
        endcase
        // The emulator halt freezes every source but the fast oscillator.
        tick = raw & (~ice_halt | (clk_sel == CS_FAST));
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            prev_r <= '0;
        else
            prev_r <= prev_nxt;
    end

endmodule : tick_select
`default_nettype wire

// file: tick_divider.sv
/*
 * Prescaler (1, 4, 16, 64) followed by the 5-bit scaler of one timer.
 * Assumes tick is a one-cycle pulse per counting event.
 */
`default_nettype none
`include "byte_timer_cfg.svh"
module tick_divider
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic [1:0] prescale,
    input wire logic [4:0] scale,
    output logic step
);
    import byte_timer_pkg::*;

    logic [5:0] pre_r;
    logic [5:0] pre_nxt;
    logic [4:0] scl_r;
    logic [4:0] scl_nxt;

    function automatic logic [5:0] pre_limit(input logic [1:0] code);
        case (code)
            2'h0: pre_limit = `PRE_LIM_1;
            2'h1: pre_limit = `PRE_LIM_4;
            2'h2: pre_limit = `PRE_LIM_16;
            default: pre_limit = `PRE_LIM_64;
        endcase
    endfunction : pre_limit

    always_comb
    begin
        pre_nxt = pre_r;
        scl_nxt = scl_r;
        step = 1'b0;
        if (tick)
        begin
            if (pre_r >= pre_limit(prescale))
            begin
                pre_nxt = 6'h00;
                if (scl_r >= scale)
                begin
                    scl_nxt = 5'h00;
                    step = 1'b1;
                end
                else
                    scl_nxt = scl_r + 5'h01;
            end
            else
                pre_nxt = pre_r + 6'h01;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pre_r <= 6'h00;
            scl_r <= 5'h00;
        end
        else
        begin
            pre_r <= pre_nxt;
            scl_r <= scl_nxt;
        end
    end

endmodule : tick_divider
`default_nettype wire

// file: byte_timer_top.sv
/*
 * Two identical 8-bit timers with period and PWM waveforms, their
 * registers on an AXI4-Lite slave, and routing of the waveforms to pins.
 * Assumes every source level and strap is synchronous to aclk.
 */
`default_nettype none
`include "byte_timer_cfg.svh"
module byte_timer_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire byte_timer_pkg::src_type src,
    input wire logic fast_osc_doubling_option,
    input wire logic narrow_pwm_width_option,
    input wire logic ice_halt,
    output byte_timer_pkg::pin_type pin_level,
    output byte_timer_pkg::pin_type pin_drive
);
    import byte_timer_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic reg_sel_type decode(input logic [11:0] addr);
        case (addr[9:2])
            `IDX_BOUND_A: decode = SEL_BOUND_A;
            `IDX_DIV_A: decode = SEL_DIV_A;
            `IDX_CTRL_A: decode = SEL_CTRL_A;
            `IDX_COUNT_A: decode = SEL_COUNT_A;
            `IDX_CTRL_B: decode = SEL_CTRL_B;
            `IDX_COUNT_B: decode = SEL_COUNT_B;
            `IDX_DIV_B: decode = SEL_DIV_B;
            `IDX_BOUND_B: decode = SEL_BOUND_B;
            default: decode = SEL_NONE;
        endcase
        if (addr[11:10] != 2'h0 || addr[1:0] != 2'h0)
            decode = SEL_NONE;
    endfunction : decode

    // ------------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------------
    logic aw_held_r;
    logic aw_held_nxt;
    logic [11:0] awaddr_r;
    logic [11:0] awaddr_nxt;
    logic w_held_r;
    logic w_held_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [3:0] wstrb_r;
    logic [3:0] wstrb_nxt;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic do_write;
    logic ar_take;
    reg_sel_type wsel;
    reg_sel_type rsel;
    logic [7:0] wbyte;

    // ------------------------------------------------------------------
    // Timer state
    // ------------------------------------------------------------------
    ctrl_type ctrl_r [2];
    ctrl_type ctrl_nxt [2];
    div_type div_r [2];
    div_type div_nxt [2];
    logic [7:0] bound_r [2];
    logic [7:0] bound_nxt [2];
    logic [7:0] count_r [2];
    logic [7:0] count_nxt [2];
    logic toggle_r [2];
    logic toggle_nxt [2];
    logic wave_r [2];
    logic wave_nxt [2];
    logic tick [2];
    logic step [2];
    logic count_wr [2];
    pin_type level_r;
    pin_type level_nxt;
    pin_type drive_r;
    pin_type drive_nxt;
    logic lvl [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : unit
            tick_select sel_i
            (
                .aclk(aclk),
                .aresetn(aresetn),
                .clk_sel(ctrl_r[g].clk_sel),
                .src(src),
                .fast_osc_doubling_option(fast_osc_doubling_option),
                .ice_halt(ice_halt),
                .tick(tick[g])
            );
            tick_divider div_i
            (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick[g]),
                .prescale(div_r[g].prescale),
                .scale(div_r[g].scale),
                .step(step[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // AXI4-Lite slave and register writes
    // ------------------------------------------------------------------
    always_comb
    begin
        do_write = aw_held_r & w_held_r & ~bvalid_r;
        aw_held_nxt = (aw_held_r | (s_axi_awvalid & awready_r)) & ~do_write;
        w_held_nxt = (w_held_r | (s_axi_wvalid & wready_r)) & ~do_write;
        awaddr_nxt = (s_axi_awvalid & awready_r) ? s_axi_awaddr : awaddr_r;
        wdata_nxt = (s_axi_wvalid & wready_r) ? s_axi_wdata : wdata_r;
        wstrb_nxt = (s_axi_wvalid & wready_r) ? s_axi_wstrb : wstrb_r;
        awready_nxt = ~aw_held_nxt;
        wready_nxt = ~w_held_nxt;
        wsel = decode(awaddr_r);
        wbyte = wdata_r[7:0];
        bvalid_nxt = bvalid_r & ~s_axi_bready;
        bresp_nxt = bresp_r;
        if (do_write)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end
        for (int t = 0; t < 2; t++)
        begin
            ctrl_nxt[t] = ctrl_r[t];
            div_nxt[t] = div_r[t];
            bound_nxt[t] = bound_r[t];
            count_wr[t] = 1'b0;
        end
        if (do_write && wstrb_r[0])
        begin
            case (wsel)
                SEL_CTRL_A: ctrl_nxt[0] = ctrl_type'(wbyte);
                SEL_CTRL_B: ctrl_nxt[1] = ctrl_type'(wbyte);
                SEL_DIV_A: div_nxt[0] = div_type'(wbyte);
                SEL_DIV_B: div_nxt[1] = div_type'(wbyte);
                SEL_BOUND_A: bound_nxt[0] = wbyte;
                SEL_BOUND_B: bound_nxt[1] = wbyte;
                SEL_COUNT_A: count_wr[0] = 1'b1;
                SEL_COUNT_B: count_wr[1] = 1'b1;
                default: count_wr[0] = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register reads; divider and bound registers are write-only
    // ------------------------------------------------------------------
    always_comb
    begin
        ar_take = s_axi_arvalid & arready_r;
        rsel = decode(s_axi_araddr);
        rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
        arready_nxt = ~rvalid_nxt;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (ar_take)
        begin
            rresp_nxt = `RESP_OKAY;
            case (rsel)
                SEL_CTRL_A: rdata_nxt = {24'h000000, ctrl_r[0]};
                SEL_CTRL_B: rdata_nxt = {24'h000000, ctrl_r[1]};
                SEL_COUNT_A: rdata_nxt = {24'h000000, count_r[0]};
                SEL_COUNT_B: rdata_nxt = {24'h000000, count_r[1]};
                SEL_NONE:
                begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = `RESP_SLVERR;
                end
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Counting and waveform
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [7:0] top;
        logic [7:0] mask;
        top = `PWM_MAX_8;
        mask = `PWM_MAX_8;
        for (int t = 0; t < 2; t++)
        begin
            count_nxt[t] = count_r[t];
            toggle_nxt[t] = toggle_r[t];
            if (div_r[t].narrow)
                mask = narrow_pwm_width_option ? `PWM_MAX_7 : `PWM_MAX_6;
            else
                mask = `PWM_MAX_8;
            top = ctrl_r[t].pwm_mode ? mask : bound_r[t];
            if (step[t])
            begin
                if (count_r[t] >= top)
                begin
                    count_nxt[t] = 8'h00;
                    toggle_nxt[t] = ~toggle_r[t];
                end
                else
                    count_nxt[t] = count_r[t] + 8'h01;
            end
            if (count_wr[t])
                count_nxt[t] = wbyte;
            // PWM stays high while the count is within the bound.
            if (ctrl_r[t].pwm_mode)
                wave_nxt[t] = (count_r[t] & mask) <= (bound_r[t] & mask);
            else
                wave_nxt[t] = toggle_r[t];
        end
    end

    // ------------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------------
    always_comb
    begin
        for (int t = 0; t < 2; t++)
            lvl[t] = wave_r[t] ^ ctrl_r[t].invert;
        drive_nxt.port_b_bit2 = ctrl_r[0].out_sel == `OUT_PIN1;
        drive_nxt.port_a_bit3 = ctrl_r[0].out_sel == `OUT_PIN2;
        drive_nxt.port_b_bit4 = ctrl_r[0].out_sel == `OUT_PIN3;
        drive_nxt.port_b_bit5 = ctrl_r[1].out_sel == `OUT_PIN1;
        drive_nxt.port_b_bit6 = ctrl_r[1].out_sel == `OUT_PIN2;
        drive_nxt.port_b_bit7 = ctrl_r[1].out_sel == `OUT_PIN3;
        // A zero field drives nothing and leaves every level low.
        level_nxt.port_b_bit2 = drive_nxt.port_b_bit2 & lvl[0];
        level_nxt.port_a_bit3 = drive_nxt.port_a_bit3 & lvl[0];
        level_nxt.port_b_bit4 = drive_nxt.port_b_bit4 & lvl[0];
        level_nxt.port_b_bit5 = drive_nxt.port_b_bit5 & lvl[1];
        level_nxt.port_b_bit6 = drive_nxt.port_b_bit6 & lvl[1];
        level_nxt.port_b_bit7 = drive_nxt.port_b_bit7 & lvl[1];
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `RESP_OKAY;
            level_r <= '0;
            drive_r <= '0;
            for (int t = 0; t < 2; t++)
            begin
                ctrl_r[t] <= ctrl_type'(`RST_CTRL);
                div_r[t] <= div_type'(`RST_DIV);
                bound_r[t] <= `RST_BOUND;
                count_r[t] <= `RST_COUNT;
                toggle_r[t] <= 1'b0;
                wave_r[t] <= 1'b0;
            end
        end
        else
        begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            level_r <= level_nxt;
            drive_r <= drive_nxt;
            for (int t = 0; t < 2; t++)
            begin
                ctrl_r[t] <= ctrl_nxt[t];
                div_r[t] <= div_nxt[t];
                bound_r[t] <= bound_nxt[t];
                count_r[t] <= count_nxt[t];
                toggle_r[t] <= toggle_nxt[t];
                wave_r[t] <= wave_nxt[t];
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign pin_level = level_r;
    assign pin_drive = drive_r;

endmodule : byte_timer_top
`default_nettype wire

// file: byte_timer_asserts.sv
/* Port checker of the dual timer block.
   Assumes it is bound into byte_timer_top. */
`default_nettype none
`include "byte_timer_cfg.svh"
module byte_timer_asserts
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire byte_timer_pkg::pin_type pin_level,
    input wire byte_timer_pkg::pin_type pin_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    import byte_timer_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready with rvalid");
    a_upper_zero: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
    a_slverr_zero: assert property (s_axi_rvalid &&
        s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read data");
    a_pin_onehot: assert property ($onehot0(pin_drive[5:3]) &&
        $onehot0(pin_drive[2:0])) else $error("two pins driven");
    a_level_gated: assert property ((pin_level & ~pin_drive) == 6'h00)
        else $error("undriven pin high");
endmodule : byte_timer_asserts
bind byte_timer_top byte_timer_asserts chk (.*);
`default_nettype wire

// file: src_model.sv
/* Source pins and oscillators facing the timers.
   Assumes levels synchronous to aclk. */
`default_nettype none
module src_model
(
    input wire logic aclk,
    input wire logic aresetn,
    output var byte_timer_pkg::src_type src
);
    timeunit 1ns;
    timeprecision 1ps;
    import byte_timer_pkg::*;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    always_comb cnt_nxt = cnt_r + 4'h1;
    always_ff @(posedge aclk) cnt_r <= aresetn ? cnt_nxt : 4'h0;
    // Every source toggles each eight cycles: one rise per sixteen.
    assign src = {7{cnt_r[3]}};
endmodule : src_model
`default_nettype wire

// file: eight_bit_timer_pwm_control_tb_top.sv
/* Self-checking bench of the dual timer block.
   Assumes the design, the checker and src_model are compiled first. */
`default_nettype none
`include "byte_timer_cfg.svh"
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    err_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module eight_bit_timer_pwm_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import byte_timer_pkg::*;
    logic aclk, aresetn = 0, ice_halt = 0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic fast_osc_doubling_option = 0, narrow_pwm_width_option = 0;
    src_type src;
    pin_type pin_level, pin_drive;
    int err_count = 0, cmp_count = 0, cyc = 0;
    logic [7:0] ri[5] = '{`IDX_CTRL_A, `IDX_COUNT_A, `IDX_CTRL_B,
        `IDX_COUNT_B, `IDX_BOUND_A};
    logic [3:0] code_t[11] = '{CS_PA0_RISE, CS_PA0_FALL, CS_PB0_RISE,
        CS_PB0_FALL, CS_PA4_RISE, CS_PA4_FALL, CS_CMP, CS_FAST,
        CS_PA0_RISE, CS_OFF, 4'h6};
    int exp_t[11] = '{10, 10, 10, 10, 10, 10, 20, 20, 0, 0, 0};
    logic halt_t[11] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0};
    byte_timer_top uut (.*);
    src_model srcm (.aclk, .aresetn, .src);
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            conclude();
        end
    end
    task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {24'h000000, dat};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge aclk);
            aw = aw && s_axi_awready !== 1'b1;
            w = w && s_axi_wready !== 1'b1;
            if (!aw) s_axi_awvalid <= 1'b0;
            if (!w) s_axi_wvalid <= 1'b0;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic half(output int n);
        logic v;
        v = pin_level.port_b_bit2;
        do @(posedge aclk); while (pin_level.port_b_bit2 === v);
        v = pin_level.port_b_bit2;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (pin_level.port_b_bit2 === v);
    endtask : half
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic v;
        int n, c;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            rd(ri[i], d, r);
            `CHK("reset", 34'h0, {r, d})
        end
        rd(8'h3F, d, r);
        `CHK("unmapped", {`RESP_SLVERR, 32'h0}, {r, d})
        wr(`IDX_COUNT_A, 8'h5A);
        rd(`IDX_COUNT_A, d, r);
        `CHK("count", 32'h5A, d)
        wr(`IDX_BOUND_A, 8'hFF);
        for (int i = 0; i < 11; i++)
        begin
            wr(`IDX_COUNT_A, 8'h00);
            ice_halt <= halt_t[i];
            fast_osc_doubling_option <= code_t[i] == CS_FAST;
            wr(`IDX_CTRL_A, {code_t[i], 4'h0});
            repeat (156) @(posedge aclk);
            wr(`IDX_CTRL_A, 8'h00);
            ice_halt <= 1'b0;
            rd(`IDX_COUNT_A, d, r);
            `CHK("events", 1'b1, d[7:0] + 1 >= exp_t[i] && d[7:0] <=
                exp_t[i] + (exp_t[i] != 0))
        end
        for (int o = 1; o < 4; o++)
        begin
            wr(`IDX_CTRL_A, 8'(o << 2));
            wr(`IDX_CTRL_B, 8'(o << 2));
            repeat (2) @(posedge aclk);
            `CHK("drive", 6'(1 << (6 - o) | 1 << (3 - o)), pin_drive)
        end
        wr(`IDX_CTRL_B, 8'h00);
        wr(`IDX_CTRL_A, 8'h04);
        repeat (3) @(posedge aclk);
        `CHK("none", 6'h20, pin_drive)
        v = pin_level.port_b_bit2;
        wr(`IDX_CTRL_A, 8'h05);
        repeat (3) @(posedge aclk);
        `CHK("invert", ~v, pin_level.port_b_bit2)
        wr(`IDX_BOUND_A, 8'h03);
        for (int p = 0; p < 4; p++)
        begin
            wr(`IDX_DIV_A, 8'(p << 5));
            wr(`IDX_CTRL_A, 8'h14);
            half(n);
            half(n);
            `CHK("half", 4 << (2 * p), n)
        end
        wr(`IDX_BOUND_A, 8'h3F);
        for (int b = 0; b < 3; b++)
        begin
            narrow_pwm_width_option <= b == 2;
            wr(`IDX_DIV_A, 8'((b != 0) << 7));
            wr(`IDX_CTRL_A, 8'h16);
            repeat (4) @(posedge aclk);
            c = 0;
            repeat (256) @(posedge aclk) c += pin_level.port_b_bit2;
            `CHK("duty", b == 0 ? 64 : b == 1 ? 256 : 128, c)
        end
        conclude();
    end
endmodule : eight_bit_timer_pwm_control_tb_top
`default_nettype wire
